//--- shared/adcsc_pkg.sv
// Constants for the converter sequence controller: register map, field positions,
// reset values and conversion timing. Shared by the controller and its prescaler.
package adcsc_pkg;

	localparam int ADCSC_ADDR_W = 5;
	localparam int ADCSC_DATA_W = 8;
	localparam int ADCSC_RES_W = 10;
	localparam int ADCSC_PRS_W = 5;
	localparam int ADCSC_CNT_W = 6;

	// Register addresses
	localparam logic [4:0] ADCSC_ADDR_CTL0 = 5'h00;
	localparam logic [4:0] ADCSC_ADDR_CTL1 = 5'h01;
	localparam logic [4:0] ADCSC_ADDR_CTL2 = 5'h02;
	localparam logic [4:0] ADCSC_ADDR_CTL3 = 5'h03;
	localparam logic [4:0] ADCSC_ADDR_CTL4 = 5'h04;
	localparam logic [4:0] ADCSC_ADDR_CTL5 = 5'h05;
	localparam logic [4:0] ADCSC_ADDR_STAT_SEQ = 5'h06;
	localparam logic [4:0] ADCSC_ADDR_STAT_RES = 5'h07;
	// Results: 5'h10 + 2*n high byte, 5'h11 + 2*n low byte
	localparam int ADCSC_RES_SEL_BIT = 4;

	// Power and interrupt control fields
	localparam int ADCSC_PWR_BIT = 7;
	localparam int ADCSC_FFC_BIT = 6;
	localparam int ADCSC_WAIT_BIT = 5;
	localparam int ADCSC_IE_BIT = 1;
	localparam int ADCSC_IF_BIT = 0;
	// Freeze field
	localparam int ADCSC_FRZ_HI = 1;
	localparam int ADCSC_FRZ_LO = 0;
	localparam logic [1:0] ADCSC_FRZ_RUN = 2'h0;
	localparam logic [1:0] ADCSC_FRZ_FINISH = 2'h2;
	localparam logic [1:0] ADCSC_FRZ_NOW = 2'h3;
	// Timing and prescale fields
	localparam int ADCSC_TEN_BIT = 7;
	localparam int ADCSC_SMP_HI = 6;
	localparam int ADCSC_SMP_LO = 5;
	localparam int ADCSC_PRS_HI = 4;
	localparam int ADCSC_PRS_LO = 0;
	// Sequence start fields
	localparam int ADCSC_LEN8_BIT = 6;
	localparam int ADCSC_SCAN_BIT = 5;
	localparam int ADCSC_MULT_BIT = 4;
	localparam int ADCSC_CH_HI = 3;
	localparam int ADCSC_CH_LO = 0;
	// Sequence status fields
	localparam int ADCSC_SCF_BIT = 7;

	// Reset values; prescale 1 gives a total divide of four
	localparam logic [7:0] ADCSC_CTL0_RST = 8'h00;
	localparam logic [7:0] ADCSC_CTL2_RST = 8'h00;
	localparam logic [7:0] ADCSC_CTL3_RST = 8'h00;
	localparam logic [7:0] ADCSC_CTL4_RST = 8'h01;
	localparam logic [7:0] ADCSC_CTL5_RST = 8'h00;

	// Conversion timing in converter clocks
	localparam logic [5:0] ADCSC_BASE_EIGHT = 6'h10;
	localparam logic [5:0] ADCSC_BASE_TEN = 6'h12;
	localparam logic [5:0] ADCSC_SAMPLE_MIN = 6'h02;
	localparam logic [2:0] ADCSC_LAST_OF_FOUR = 3'h3;
	localparam logic [2:0] ADCSC_LAST_OF_EIGHT = 3'h7;

endpackage

//--- hw/adcsc_prescaler.sv
// Converter clock prescaler: modulo (value + 1) counter feeding a divide-by-two.
// Assumes the bus clock domain only; the divided clock is also given as a tick enable.
`timescale 1ns/1ps
module adcsc_prescaler
	import adcsc_pkg::*;
#(
	parameter int PRS_W = ADCSC_PRS_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic enable,
	input wire logic [PRS_W-1:0] prescale,
	output logic conv_clk,
	output logic conv_tick
);

	logic [PRS_W-1:0] cnt_reg, cnt_next;
	logic level_reg, level_next;
	logic tick_reg, tick_next;
	logic wrap;

	always_comb begin
		wrap = (cnt_reg >= prescale);
		cnt_next = cnt_reg;
		level_next = level_reg;
		tick_next = 1'b0;
		if (!enable) begin
			// Clock gated off while powered down
			cnt_next = '0;
			level_next = 1'b0;
		end else if (wrap) begin
			cnt_next = '0;
			level_next = !level_reg;
			tick_next = !level_reg;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
			level_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
			level_reg <= level_next;
			tick_reg <= tick_next;
		end
	end

	assign conv_clk = level_reg;
	assign conv_tick = tick_reg;

endmodule

//--- hw/adcsc_controller.sv
// Sequencing and register logic of a sixteen-channel successive-approximation converter.
// Assumes a converter core that presents its result on conv_data by the last converter
// clock of a conversion, and register strobes synchronous to clk.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adcsc_controller
	import adcsc_pkg::*;
#(
	parameter int RES_W = ADCSC_RES_W,
	parameter int NUM_RES = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADCSC_ADDR_W-1:0] addr,
	input wire logic [ADCSC_DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [ADCSC_DATA_W-1:0] rdata,
	input wire logic special_mode,
	input wire logic wait_mode,
	input wire logic background_debug_active,
	input wire logic [RES_W-1:0] conv_data,
	output logic converter_power_up,
	output logic conv_clk,
	output logic conv_sample,
	output logic [3:0] conv_channel,
	output logic conv_ten_bit,
	output logic conv_busy,
	output logic irq
);

	typedef enum logic [0:0] {
		ADCSC_IDLE,
		ADCSC_RUN
	} adcsc_state_e;

	// Control registers
	logic [7:0] ctl0_reg, ctl0_next;
	logic [7:0] ctl2_reg, ctl2_next;
	logic [7:0] ctl3_reg, ctl3_next;
	logic [7:0] ctl4_reg, ctl4_next;
	logic [7:0] ctl5_reg, ctl5_next;
	logic wr_ctl0, wr_ctl2, wr_ctl3, wr_ctl4, wr_ctl5;
	logic res_access, res_read;
	logic [2:0] res_sel;

	assign wr_ctl0 = wr && (addr == ADCSC_ADDR_CTL0);
	assign wr_ctl2 = wr && (addr == ADCSC_ADDR_CTL2);
	assign wr_ctl3 = wr && (addr == ADCSC_ADDR_CTL3);
	assign wr_ctl4 = wr && (addr == ADCSC_ADDR_CTL4);
	assign wr_ctl5 = wr && (addr == ADCSC_ADDR_CTL5);
	assign res_access = (wr || rd) && addr[ADCSC_RES_SEL_BIT];
	assign res_read = rd && addr[ADCSC_RES_SEL_BIT];
	assign res_sel = addr[3:1];

	always_comb begin
		ctl0_next = ctl0_reg;
		ctl2_next = ctl2_reg;
		ctl3_next = ctl3_reg;
		ctl4_next = ctl4_reg;
		ctl5_next = ctl5_reg;
		if (wr_ctl0) begin
			ctl0_next = wdata;
		end
		if (wr_ctl2) begin
			// Interrupt flag is not stored here and cannot be written
			ctl2_next = wdata;
			ctl2_next[ADCSC_IF_BIT] = 1'b0;
		end
		if (wr_ctl3) begin
			ctl3_next = wdata;
		end
		if (wr_ctl4) begin
			ctl4_next = wdata;
		end
		if (wr_ctl5) begin
			ctl5_next = wdata;
		end
		// The reserved register has no storage, so a write changes nothing
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctl0_reg <= ADCSC_CTL0_RST;
			ctl2_reg <= ADCSC_CTL2_RST;
			ctl3_reg <= ADCSC_CTL3_RST;
			ctl4_reg <= ADCSC_CTL4_RST;
			ctl5_reg <= ADCSC_CTL5_RST;
		end else if (ce) begin
			ctl0_reg <= ctl0_next;
			ctl2_reg <= ctl2_next;
			ctl3_reg <= ctl3_next;
			ctl4_reg <= ctl4_next;
			ctl5_reg <= ctl5_next;
		end
	end

	// Field decode
	logic pwr_on, fast_clear, wait_stop, irq_en, ten_bit;
	logic [1:0] freeze_sel, smp_sel;
	logic [5:0] sample_ticks, conv_total;
	logic conv_tick;

	assign pwr_on = ctl2_reg[ADCSC_PWR_BIT];
	assign fast_clear = ctl2_reg[ADCSC_FFC_BIT];
	assign wait_stop = ctl2_reg[ADCSC_WAIT_BIT];
	assign irq_en = ctl2_reg[ADCSC_IE_BIT];
	assign freeze_sel = ctl3_reg[ADCSC_FRZ_HI:ADCSC_FRZ_LO];
	assign ten_bit = ctl4_reg[ADCSC_TEN_BIT];
	assign smp_sel = ctl4_reg[ADCSC_SMP_HI:ADCSC_SMP_LO];
	assign sample_ticks = ADCSC_SAMPLE_MIN << smp_sel;
	assign conv_total = (ten_bit ? ADCSC_BASE_TEN : ADCSC_BASE_EIGHT) + sample_ticks;

	// Converter clock, gated off while powered down
	adcsc_prescaler #(
		.PRS_W(ADCSC_PRS_W)
	) u_prescaler (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.enable(pwr_on),
		.prescale(ctl4_reg[ADCSC_PRS_HI:ADCSC_PRS_LO]),
		.conv_clk(conv_clk),
		.conv_tick(conv_tick)
	);

	// Sequencer
	adcsc_state_e state_reg, state_next;
	logic [2:0] idx_reg, idx_next;
	logic [5:0] cnt_reg, cnt_next;
	logic abort, start, stall, conv_done, seq_done;
	logic [2:0] last_idx;

	// A write to CTL0, CTL2, CTL3 or CTL4, or power-down, drops the sequence; only a start write resumes
	assign abort = wr_ctl0 || wr_ctl2 || wr_ctl3 || wr_ctl4 || !pwr_on;
	assign start = wr_ctl5 && pwr_on;
	assign last_idx = ctl5_reg[ADCSC_LEN8_BIT] ? ADCSC_LAST_OF_EIGHT : ADCSC_LAST_OF_FOUR;

	always_comb begin
		stall = 1'b0;
		if (wait_stop && wait_mode) begin
			stall = 1'b1;
		end
		if (background_debug_active) begin
			case (freeze_sel)
				ADCSC_FRZ_NOW: stall = 1'b1;
				ADCSC_FRZ_FINISH: begin
					// Hold only between conversions, so the current one completes
					if (cnt_reg == 6'h00) begin
						stall = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		cnt_next = cnt_reg;
		conv_done = 1'b0;
		seq_done = 1'b0;
		case (state_reg)
			ADCSC_IDLE: begin
				cnt_next = 6'h00;
			end
			ADCSC_RUN: begin
				if (conv_tick && !stall) begin
					if (cnt_reg == conv_total - 6'h01) begin
						cnt_next = 6'h00;
						conv_done = 1'b1;
						if (idx_reg == last_idx) begin
							seq_done = 1'b1;
							idx_next = 3'h0;
							if (!ctl5_reg[ADCSC_SCAN_BIT]) begin
								state_next = ADCSC_IDLE;
							end
						end else begin
							idx_next = idx_reg + 3'h1;
						end
					end else begin
						cnt_next = cnt_reg + 6'h01;
					end
				end
			end
			default: begin
				state_next = ADCSC_IDLE;
			end
		endcase
		if (start) begin
			// Restart from the first conversion
			state_next = ADCSC_RUN;
			idx_next = 3'h0;
			cnt_next = 6'h00;
		end else if (abort) begin
			state_next = ADCSC_IDLE;
			idx_next = 3'h0;
			cnt_next = 6'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ADCSC_IDLE;
			idx_reg <= 3'h0;
			cnt_reg <= 6'h00;
		end else if (ce) begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			cnt_reg <= cnt_next;
		end
	end

	// Results and completion flags
	logic [RES_W-1:0] res_mem [NUM_RES];
	logic [RES_W-1:0] res_mem_next [NUM_RES];
	logic [NUM_RES-1:0] ccf_reg, ccf_next;
	logic [NUM_RES-1:0] seen_reg, seen_next;
	logic scf_reg, scf_next;
	logic status_read;

	assign status_read = rd && ((addr == ADCSC_ADDR_STAT_SEQ) || (addr == ADCSC_ADDR_STAT_RES));

	always_comb begin
		res_mem_next = res_mem;
		ccf_next = ccf_reg;
		seen_next = seen_reg;
		scf_next = scf_reg;
		if (status_read) begin
			seen_next = ccf_reg;
		end
		if (res_access) begin
			if (fast_clear) begin
				ccf_next[res_sel] = 1'b0;
				seen_next[res_sel] = 1'b0;
			end else if (rd && seen_reg[res_sel]) begin
				ccf_next[res_sel] = 1'b0;
				seen_next[res_sel] = 1'b0;
			end
		end
		if (fast_clear && res_read) begin
			scf_next = 1'b0;
		end
		if (wr_ctl5) begin
			ccf_next = '0;
			seen_next = '0;
			scf_next = 1'b0;
		end
		// Hardware set wins over a clear in the same cycle
		if (conv_done) begin
			res_mem_next[idx_reg] = conv_data;
			ccf_next[idx_reg] = 1'b1;
		end
		if (seq_done) begin
			scf_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_RES; i++) begin
				res_mem[i] <= '0;
			end
			ccf_reg <= '0;
			seen_reg <= '0;
			scf_reg <= 1'b0;
		end else if (ce) begin
			res_mem <= res_mem_next;
			ccf_reg <= ccf_next;
			seen_reg <= seen_next;
			scf_reg <= scf_next;
		end
	end

	// Register read-back, one cycle after the read strobe
	logic [7:0] rdata_reg, rdata_next;
	logic [RES_W-1:0] res_word;

	assign res_word = res_mem[res_sel];

	always_comb begin
		rdata_next = 8'h00;
		if (rd) begin
			if (addr[ADCSC_RES_SEL_BIT]) begin
				// Left-justified: high byte holds the top eight bits
				if (addr[0]) begin
					rdata_next = {res_word[1:0], 6'h00};
				end else begin
					rdata_next = res_word[9:2];
				end
			end else begin
				case (addr)
					ADCSC_ADDR_CTL0: rdata_next = ctl0_reg;
					ADCSC_ADDR_CTL1: rdata_next = special_mode ? 8'h00 : 8'h00;
					ADCSC_ADDR_CTL2: begin
						rdata_next = ctl2_reg;
						rdata_next[ADCSC_IF_BIT] = scf_reg;
					end
					ADCSC_ADDR_CTL3: rdata_next = ctl3_reg;
					ADCSC_ADDR_CTL4: rdata_next = ctl4_reg;
					ADCSC_ADDR_CTL5: rdata_next = ctl5_reg;
					ADCSC_ADDR_STAT_SEQ: begin
						rdata_next = {scf_reg, 4'h0, idx_reg};
					end
					ADCSC_ADDR_STAT_RES: rdata_next = ccf_reg;
					default: rdata_next = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (ce) begin
			rdata_reg <= rdata_next;
		end
	end

	// Converter core controls
	logic [3:0] chan_sel;
	logic [3:0] base_chan;

	assign base_chan = ctl5_reg[ADCSC_CH_HI:ADCSC_CH_LO];

	always_comb begin
		chan_sel = base_chan;
		if (ctl5_reg[ADCSC_MULT_BIT]) begin
			if (ctl5_reg[ADCSC_LEN8_BIT]) begin
				chan_sel = {base_chan[3], idx_reg};
			end else begin
				chan_sel = {base_chan[3:2], idx_reg[1:0]};
			end
		end
	end

	assign rdata = rdata_reg;
	assign converter_power_up = pwr_on;
	assign conv_busy = (state_reg == ADCSC_RUN);
	assign conv_sample = conv_busy && (cnt_reg < sample_ticks);
	assign conv_channel = chan_sel;
	assign conv_ten_bit = ten_bit;
	assign irq = scf_reg && irq_en;

endmodule

//--- test/adcsc_props.sv
// Port-level checks for the converter sequence controller.
// Assumes one bus clock domain; sees only the controller's ports.
`timescale 1ns/1ps
module adcsc_props
	import adcsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic wait_mode,
	input wire logic background_debug_active,
	input wire logic converter_power_up,
	input wire logic conv_clk,
	input wire logic conv_sample,
	input wire logic conv_ten_bit,
	input wire logic conv_busy,
	input wire logic irq
);
	logic ie_reg;
	logic clk_d;
	logic ok_reg;
	logic [4:0] prs_reg;
	logic [4:0] cnt_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence ctl_wr(a);
		wr && ce && addr == a;
	endsequence
	// Shadow of enable and prescale; bus clocks between converter clock edges
	always_ff @(posedge clk) begin
		clk_d <= conv_clk;
		if (rst) begin
			ie_reg <= 1'b0;
			prs_reg <= 5'h01;
		end else if (ce && wr && addr == ADCSC_ADDR_CTL2) begin
			ie_reg <= wdata[ADCSC_IE_BIT];
		end else if (ce && wr && addr == ADCSC_ADDR_CTL4) begin
			prs_reg <= wdata[4:0];
		end
		if (rst || !ce || !converter_power_up || wait_mode || background_debug_active
				|| (wr && addr[4:1] == 4'h2)) begin
			cnt_reg <= 5'h00;
			ok_reg <= 1'b0;
		end else if (conv_clk != clk_d) begin
			cnt_reg <= 5'h00;
			ok_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end
	irq_gate_a: assert property (irq |-> ie_reg)
		else $error("irq high with enable clear");
	rsvd_read_a: assert property (rd && ce && addr == ADCSC_ADDR_CTL1 |=>
		rdata == 8'h00)
		else $error("reserved register read not zero");
	power_bit_a: assert property (ctl_wr(ADCSC_ADDR_CTL2) |=> converter_power_up == $past(wdata[7]))
		else $error("power output does not follow write");
	power_gate_a: assert property (!converter_power_up && !$past(converter_power_up)
		|-> !conv_clk && !conv_busy)
		else $error("activity while powered down");
	abort_zero_a: assert property (ctl_wr(ADCSC_ADDR_CTL0) |=> !conv_busy)
		else $error("busy after control zero write");
	abort_two_a: assert property (ctl_wr(ADCSC_ADDR_CTL2) |=> !conv_busy)
		else $error("busy after power control write");
	abort_three_a: assert property (ctl_wr(ADCSC_ADDR_CTL3) |=> !conv_busy)
		else $error("busy after freeze control write");
	abort_four_a: assert property (ctl_wr(ADCSC_ADDR_CTL4) |=> !conv_busy ##1
		(!conv_busy || $past(wr && addr == ADCSC_ADDR_CTL5)))
		else $error("busy after timing control write");
	start_run_a: assert property (wr && ce && addr == ADCSC_ADDR_CTL5
		&& converter_power_up && !wait_mode && !background_debug_active |=> conv_busy)
		else $error("start write did not run");
	ten_bit_a: assert property (ctl_wr(ADCSC_ADDR_CTL4) |=> conv_ten_bit == $past(wdata[7]))
		else $error("resolution output wrong");
	start_sample_a: assert property (wr && ce && addr == ADCSC_ADDR_CTL5
		&& converter_power_up |=> conv_sample)
		else $error("no sampling phase after start");
	clk_period_a: assert property (ok_reg && conv_clk != clk_d |-> cnt_reg == prs_reg)
		else $error("converter clock half period wrong");
endmodule

bind adcsc_controller adcsc_props adcsc_props_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode),
	.background_debug_active(background_debug_active), .converter_power_up(converter_power_up),
	.conv_clk(conv_clk), .conv_sample(conv_sample), .conv_ten_bit(conv_ten_bit),
	.conv_busy(conv_busy), .irq(irq));

//--- test/adcsc_core_model.sv
// Behavioural analog multiplexer and converter core.
// Assumes the controller takes conv_data only at the end of a conversion.
`timescale 1ns/1ps
module adcsc_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic converter_power_up,
	input wire logic conv_sample,
	input wire logic conv_ten_bit,
	input wire logic [3:0] conv_channel,
	output logic [9:0] conv_data
);
	logic [9:0] data_next;
	always_comb begin
		// Eight-bit results come left-justified
		data_next = {conv_channel, 6'h2d} & (conv_ten_bit ? 10'h3ff : 10'h3fc);
		// Unsettled while sampling or powered down
		if (conv_sample || !converter_power_up) begin
			data_next = ~conv_data;
		end
	end
	always_ff @(posedge clk) begin
		conv_data <= rst ? 10'h2aa : data_next;
	end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the converter sequence controller.
// Assumes the behavioural core model on the converter side.
`timescale 1ns/1ps
module tb_top
	import adcsc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic special_mode = 1'b0;
	logic wait_mode = 1'b0;
	logic dbg = 1'b0;
	logic [9:0] conv_data;
	logic [7:0] rdata;
	logic [7:0] v;
	logic [3:0] chan;
	logic pwr, cclk, samp, ten, busy, irq;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int per;
	logic [7:0] row_ctl4 [6] = '{8'h01, 8'ha1, 8'h40, 8'he3, 8'h07, 8'h81};
	int row_tot [6] = '{18, 22, 24, 34, 18, 20};
	logic [7:0] row_lo [6] = '{8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h40};
	adcsc_controller adcsc_controller_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .special_mode(special_mode),
		.wait_mode(wait_mode), .background_debug_active(dbg), .conv_data(conv_data),
		.converter_power_up(pwr), .conv_clk(cclk), .conv_sample(samp), .conv_channel(chan),
		.conv_ten_bit(ten), .conv_busy(busy), .irq(irq));
	adcsc_core_model adcsc_core_model_i (.clk(clk), .rst(rst), .converter_power_up(pwr),
		.conv_sample(samp), .conv_ten_bit(ten), .conv_channel(chan), .conv_data(conv_data));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic summarize();
		if (failures == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrt(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdt(input logic [4:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wbusy();
		int k;
		k = 0;
		// Let a start taken at this edge reach busy
		#1;
		while (busy !== 1'b0 && k < 3000) begin
			@(posedge clk);
			#1 k++;
		end
		chk("busy", {7'h0, busy}, 8'h00);
	endtask
	initial begin
		wt(5);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rdt(5'(i));
			chk("reset", v, i == 4 ? ADCSC_CTL4_RST : 8'h00);
		end
		special_mode <= 1'b1;
		wrt(5'h01, 8'hff);
		rdt(5'h01);
		chk("rsvd", v, 8'h00);
		special_mode <= 1'b0;
		// Timing rows: sample time, resolution and prescale
		for (int i = 0; i < 6; i++) begin
			per = 2 * (row_ctl4[i][4:0] + 1);
			wrt(5'h02, 8'h80);
			wt(8);
			wrt(5'h04, row_ctl4[i]);
			wrt(5'h05, 8'h00);
			wt((row_tot[i] - 1) * per - 8);
			rdt(5'h07);
			chk("early", v, 8'h00);
			wt(2 * per + 10);
			rdt(5'h07);
			chk("first", {7'h0, v[0]}, 8'h01);
			wbusy();
			rdt(5'h07);
			chk("flags", v, 8'h0f);
			rdt(5'h10);
			chk("hi", v, 8'h0b);
			rdt(5'h11);
			chk("lo", v, row_lo[i]);
			rdt(5'h07);
			chk("clear", v, 8'h0e);
		end
		wrt(5'h05, 8'h00);
		wbusy();
		rdt(5'h12);
		rdt(5'h07);
		chk("noclr", v, 8'h0f);
		wrt(5'h02, 8'hc0);
		wrt(5'h05, 8'h00);
		wbusy();
		rdt(5'h13);
		rdt(5'h07);
		chk("fast", v, 8'h0d);
		wrt(5'h05, 8'h14);
		wbusy();
		rdt(5'h16);
		chk("mult", v, 8'h7b);
		wrt(5'h02, 8'h82);
		wrt(5'h05, 8'h40);
		wbusy();
		rdt(5'h07);
		chk("len8", v, 8'hff);
		chk("irq", {7'h0, irq}, 8'h01);
		wrt(5'h02, 8'h80);
		rdt(5'h02);
		chk("ctl2", v, 8'h81);
		chk("mask", {7'h0, irq}, 8'h00);
		wrt(5'h05, 8'h00);
		rdt(5'h06);
		chk("seq", v & 8'h80, 8'h00);
		wrt(5'h02, 8'h83);
		rdt(5'h02);
		chk("ro", v, 8'h82);
		wrt(5'h05, 8'h20);
		wt(400);
		rdt(5'h06);
		chk("scan", {v[7], 5'h0, irq, busy}, 8'h83);
		wrt(5'h05, 8'h20);
		rdt(5'h07);
		chk("restart", v, 8'h00);
		// Abort by CTL0, CTL2, CTL3 and CTL4 in turn
		for (int i = 0; i < 4; i++) begin
			wrt(5'(i + (i > 0)), i == 3 ? 8'h01 : 8'h82);
			wt(20);
			chk("abort", {7'h0, busy}, 8'h00);
			wrt(5'h05, 8'h20);
		end
		wrt(5'h02, 8'h00);
		wrt(5'h05, 8'h00);
		wt(30);
		chk("off", {5'h0, pwr, cclk, busy}, 8'h00);
		wrt(5'h02, 8'ha0);
		wt(8);
		wait_mode <= 1'b1;
		wrt(5'h05, 8'h00);
		wt(400);
		rdt(5'h07);
		chk("wstop", v, 8'h00);
		wrt(5'h02, 8'h80);
		wrt(5'h05, 8'h00);
		wt(400);
		rdt(5'h07);
		chk("wrun", v, 8'h0f);
		wait_mode <= 1'b0;
		wrt(5'h03, 8'h02);
		wrt(5'h05, 8'h00);
		wt(20);
		dbg <= 1'b1;
		wt(400);
		rdt(5'h07);
		chk("frzfin", v, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wrt(5'h03, 8'(i + (i > 0)));
			wrt(5'h05, 8'h00);
			wt(400);
			rdt(5'h07);
			chk("frz", v, i == 0 ? 8'h0f : 8'h00);
		end
		dbg <= 1'b0;
		// Clock enable low: the write below must not land
		ce <= 1'b0;
		wrt(5'h02, 8'h00);
		ce <= 1'b1;
		rdt(5'h02);
		chk("hold", v, 8'h80);
		summarize();
	end
endmodule
